// ### rtl/pam_pkg.sv
package pam_pkg;

  localparam int unsigned PAM_PHYS_W   = 14;
  localparam int unsigned PAM_DIR_W    = 8;
  localparam int unsigned PAM_DATA_W   = 8;
  localparam int unsigned PAM_OFS_W    = 6;

  // Registers inside the direct space
  localparam logic [7:0]  PAM_INDIRECT_OFS = 8'h0e;
  localparam logic [7:0]  PAM_POINTER_OFS  = 8'h0f;
  localparam logic [7:0]  PAM_BANK_OFS     = 8'h1f;

  // Paging window 0xc0..0xff: both upper direct bits set
  localparam logic [7:0]  PAM_WINDOW_BASE  = 8'hc0;
  localparam logic [1:0]  PAM_WINDOW_SEL   = 2'h3;
  localparam logic [5:0]  PAM_PAGE_OFS_MAX = 6'h3f;

  // Reach limits of the short addressing modes
  localparam logic [13:0] PAM_TINY_LIMIT   = 14'h0010;
  localparam logic [13:0] PAM_SHORT_LIMIT  = 14'h0020;
  localparam logic [13:0] PAM_DIRECT_LIMIT = 14'h0100;

  // Values after reset
  localparam logic [13:0] PAM_RESET_FETCH  = 14'h3ffd;
  localparam logic [7:0]  PAM_BANK_RESET   = 8'h00;
  localparam logic [7:0]  PAM_POINTER_RESET = 8'h00;
  localparam logic [7:0]  PAM_RDATA_RESET  = 8'h00;
  localparam logic [13:0] PAM_MADDR_RESET  = 14'h0000;

  typedef enum logic [2:0] {
    PAM_MODE_INHERENT,
    PAM_MODE_IMMEDIATE,
    PAM_MODE_TINY,
    PAM_MODE_SHORT,
    PAM_MODE_DIRECT,
    PAM_MODE_EXTENDED
  } pam_mode_t;

  typedef enum logic [1:0] {
    PAM_OP_ARITH,
    PAM_OP_CLRLDST,
    PAM_OP_JUMP,
    PAM_OP_OTHER
  } pam_op_t;

  typedef enum logic [1:0] {
    PAM_KIND_MEM,
    PAM_KIND_POINTER,
    PAM_KIND_BANK,
    PAM_KIND_INDIRECT
  } pam_kind_t;

  typedef enum logic [1:0] {
    PAM_ST_IDLE,
    PAM_ST_MEM,
    PAM_ST_RDWAIT
  } pam_state_t;

endpackage : pam_pkg

// ### rtl/pam_addr_resolve.sv
`timescale 1ns/1ps
module pam_addr_resolve (
  input  wire logic [7:0]         dir_addr,  // Direct-space address
  input  wire logic [7:0]         bank,      // Current window bank select
  output pam_pkg::pam_kind_t      kind,      // Target class
  output logic [13:0]             phys       // Physical address
);

  always_comb
  begin
    phys = {6'h00, dir_addr};
    kind = pam_pkg::PAM_KIND_MEM;
    if (dir_addr[7:6] == pam_pkg::PAM_WINDOW_SEL)
    begin
      phys = {bank, dir_addr[5:0]};
    end
    else if (dir_addr == pam_pkg::PAM_POINTER_OFS)
    begin
      kind = pam_pkg::PAM_KIND_POINTER;
    end
    else if (dir_addr == pam_pkg::PAM_BANK_OFS)
    begin
      kind = pam_pkg::PAM_KIND_BANK;
    end
    else if (dir_addr == pam_pkg::PAM_INDIRECT_OFS)
    begin
      kind = pam_pkg::PAM_KIND_INDIRECT;
    end
  end

endmodule : pam_addr_resolve

// ### rtl/pam_mode_check.sv
`timescale 1ns/1ps
module pam_mode_check (
  input  wire pam_pkg::pam_mode_t mode,   // Addressing mode
  input  wire pam_pkg::pam_op_t   op,     // Operation class
  input  wire logic [13:0]        addr,   // Operand or jump address
  output logic                    legal   // Mode, op and reach agree
);

  always_comb
  begin
    legal = 1'b0;
    case (mode)
      pam_pkg::PAM_MODE_INHERENT,
      pam_pkg::PAM_MODE_IMMEDIATE:
        legal = (op != pam_pkg::PAM_OP_JUMP);
      pam_pkg::PAM_MODE_TINY:
        legal = (op == pam_pkg::PAM_OP_ARITH) && (addr < pam_pkg::PAM_TINY_LIMIT);
      pam_pkg::PAM_MODE_SHORT:
        legal = (op == pam_pkg::PAM_OP_CLRLDST) && (addr < pam_pkg::PAM_SHORT_LIMIT);
      pam_pkg::PAM_MODE_DIRECT:
        legal = (op != pam_pkg::PAM_OP_JUMP) && (addr < pam_pkg::PAM_DIRECT_LIMIT);
      pam_pkg::PAM_MODE_EXTENDED:
        legal = (op == pam_pkg::PAM_OP_JUMP);
      default:
        legal = 1'b0;
    endcase
  end

endmodule : pam_mode_check

// ### rtl/paged_address_mapper.sv
`timescale 1ns/1ps
module paged_address_mapper (
  input  wire logic                clk,            // System clock, 40 MHz
  input  wire logic                reset,          // Asynchronous, active high
  input  wire logic                clk_en,         // Freezes all state when low
  input  wire logic                core_req,       // Access request pulse
  input  wire logic                core_we,        // 1 write, 0 read
  input  wire pam_pkg::pam_mode_t  core_mode,      // Addressing mode
  input  wire pam_pkg::pam_op_t    core_op,        // Operation class
  input  wire logic [13:0]         core_addr,      // Operand or jump address
  input  wire logic [7:0]          core_wdata,     // Store data
  input  wire logic [7:0]          core_imm,       // Stream byte after opcode
  output logic                     core_ready,     // Idle, request taken
  output logic                     core_ack,       // Access done pulse
  output logic                     core_err,       // Illegal mode pulse
  output logic [7:0]               core_rdata,     // Load data
  output logic [13:0]              fetch_addr,     // Program fetch address
  output logic [7:0]               bank_select,    // Window bank register
  output logic [7:0]               pointer,        // Indirect pointer register
  output logic                     mem_req,        // Memory strobe pulse
  output logic                     mem_we,         // Memory write
  output logic [13:0]              mem_addr,       // Physical address
  output logic [7:0]               mem_wdata,      // Memory write data
  input  wire logic [7:0]          mem_rdata       // Read data, cycle after strobe
);

  typedef struct packed {
    pam_pkg::pam_state_t state;
    logic [7:0]          bank;
    logic [7:0]          ptr;
    logic [13:0]         fetch;
    logic                ready;
    logic                ack;
    logic                err;
    logic [7:0]          rdata;
    logic                mreq;
    logic                mwe;
    logic [13:0]         maddr;
    logic [7:0]          mwdata;
  } pam_regs_t;

  localparam pam_regs_t PAM_REGS_RESET = '{
    state:  pam_pkg::PAM_ST_IDLE,
    bank:   pam_pkg::PAM_BANK_RESET,
    ptr:    pam_pkg::PAM_POINTER_RESET,
    fetch:  pam_pkg::PAM_RESET_FETCH,
    ready:  1'b1,
    ack:    1'b0,
    err:    1'b0,
    rdata:  pam_pkg::PAM_RDATA_RESET,
    mreq:   1'b0,
    mwe:    1'b0,
    maddr:  pam_pkg::PAM_MADDR_RESET,
    mwdata: pam_pkg::PAM_RDATA_RESET
  };

  pam_regs_t          regs_r;
  pam_regs_t          regs_nxt;
  pam_pkg::pam_kind_t kind_dir;
  pam_pkg::pam_kind_t kind_ptr;
  logic [13:0]        phys_dir;
  logic [13:0]        phys_ptr;
  logic               legal;
  pam_pkg::pam_kind_t eff_kind;
  logic [13:0]        eff_phys;
  logic               take;

  pam_addr_resolve u_resolve_dir (
    .dir_addr (core_addr[7:0]),
    .bank     (regs_r.bank),
    .kind     (kind_dir),
    .phys     (phys_dir)
  );

  pam_addr_resolve u_resolve_ptr (
    .dir_addr (regs_r.ptr),
    .bank     (regs_r.bank),
    .kind     (kind_ptr),
    .phys     (phys_ptr)
  );

  pam_mode_check u_mode_check (
    .mode  (core_mode),
    .op    (core_op),
    .addr  (core_addr),
    .legal (legal)
  );

  assign take = clk_en && (regs_r.state == pam_pkg::PAM_ST_IDLE) && core_req;

  always_comb
  begin
    eff_kind = kind_dir;
    eff_phys = phys_dir;
    if (kind_dir == pam_pkg::PAM_KIND_INDIRECT)
    begin
      eff_phys = phys_ptr;
      // Pointer aimed at the port itself lands on plain memory
      eff_kind = (kind_ptr == pam_pkg::PAM_KIND_INDIRECT) ? pam_pkg::PAM_KIND_MEM : kind_ptr;
    end
  end

  always_comb
  begin
    regs_nxt      = regs_r;
    regs_nxt.ack  = 1'b0;
    regs_nxt.err  = 1'b0;
    regs_nxt.mreq = 1'b0;
    case (regs_r.state)
      pam_pkg::PAM_ST_IDLE:
      begin
        if (core_req)
        begin
          if (!legal)
          begin
            regs_nxt.ack = 1'b1;
            regs_nxt.err = 1'b1;
          end
          else
          begin
            case (core_mode)
              pam_pkg::PAM_MODE_INHERENT:
                regs_nxt.ack = 1'b1;
              pam_pkg::PAM_MODE_IMMEDIATE:
              begin
                regs_nxt.rdata = core_imm;
                regs_nxt.ack   = 1'b1;
              end
              pam_pkg::PAM_MODE_EXTENDED:
              begin
                regs_nxt.fetch = core_addr;
                regs_nxt.ack   = 1'b1;
              end
              default:
              begin
                case (eff_kind)
                  pam_pkg::PAM_KIND_POINTER:
                  begin
                    if (core_we)
                      regs_nxt.ptr = core_wdata;
                    else
                      regs_nxt.rdata = regs_r.ptr;
                    regs_nxt.ack = 1'b1;
                  end
                  pam_pkg::PAM_KIND_BANK:
                  begin
                    if (core_we)
                      regs_nxt.bank = core_wdata;
                    else
                      regs_nxt.rdata = regs_r.bank;
                    regs_nxt.ack = 1'b1;
                  end
                  default:
                  begin
                    // physical address from the resolver: bank and offset in the window, pointer target through the indirect port, direct address elsewhere
                    regs_nxt.state  = pam_pkg::PAM_ST_MEM;
                    regs_nxt.mreq   = 1'b1;
                    regs_nxt.mwe    = core_we;
                    regs_nxt.maddr  = eff_phys;
                    regs_nxt.mwdata = core_wdata;
                  end
                endcase
              end
            endcase
          end
        end
      end
      pam_pkg::PAM_ST_MEM:
      begin
        if (regs_r.mwe)
        begin
          regs_nxt.state = pam_pkg::PAM_ST_IDLE;
          regs_nxt.ack   = 1'b1;
        end
        else
        begin
          regs_nxt.state = pam_pkg::PAM_ST_RDWAIT;
        end
      end
      pam_pkg::PAM_ST_RDWAIT:
      begin
        regs_nxt.rdata = mem_rdata;
        regs_nxt.ack   = 1'b1;
        regs_nxt.state = pam_pkg::PAM_ST_IDLE;
      end
      default:
        regs_nxt.state = pam_pkg::PAM_ST_IDLE;
    endcase
    regs_nxt.ready = (regs_nxt.state == pam_pkg::PAM_ST_IDLE);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      regs_r <= PAM_REGS_RESET;
    else if (clk_en)
      regs_r <= regs_nxt;
  end

  assign core_ready  = regs_r.ready;
  assign core_ack    = regs_r.ack;
  assign core_err    = regs_r.err;
  assign core_rdata  = regs_r.rdata;
  assign fetch_addr  = regs_r.fetch;
  assign bank_select = regs_r.bank;
  assign pointer     = regs_r.ptr;
  assign mem_req     = regs_r.mreq;
  assign mem_we      = regs_r.mwe;
  assign mem_addr    = regs_r.maddr;
  assign mem_wdata   = regs_r.mwdata;

  a_window_map: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_mode == pam_pkg::PAM_MODE_DIRECT
      && core_addr[7:6] == pam_pkg::PAM_WINDOW_SEL
    |=> mem_req && mem_addr == {$past(regs_r.bank), $past(core_addr[5:0])})
    else $error("window access not mapped to bank and offset");

  a_bank_write: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_we && core_mode != pam_pkg::PAM_MODE_EXTENDED
      && core_mode != pam_pkg::PAM_MODE_IMMEDIATE
      && core_mode != pam_pkg::PAM_MODE_INHERENT
      && core_addr[7:0] == pam_pkg::PAM_BANK_OFS
    |=> bank_select == $past(core_wdata) && core_ack && !mem_req)
    else $error("bank select write not stored");

  a_indirect_port: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_mode == pam_pkg::PAM_MODE_DIRECT
      && core_addr[7:0] == pam_pkg::PAM_INDIRECT_OFS && pointer < pam_pkg::PAM_INDIRECT_OFS
    |=> mem_req && mem_addr == {6'h00, $past(pointer)})
    else $error("indirect port did not follow pointer");

  a_direct_low: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_mode == pam_pkg::PAM_MODE_DIRECT
      && core_addr[7:0] >= 8'h20 && core_addr[7:6] != pam_pkg::PAM_WINDOW_SEL
    |=> mem_req && mem_addr == {6'h00, $past(core_addr[7:0])})
    else $error("direct address not passed through");

  a_tiny_limit: assert property (@(posedge clk) disable iff (reset)
    take && core_mode == pam_pkg::PAM_MODE_TINY
      && (core_addr >= pam_pkg::PAM_TINY_LIMIT || core_op != pam_pkg::PAM_OP_ARITH)
    |=> core_err && core_ack && !mem_req)
    else $error("tiny mode reach not enforced");

  a_short_limit: assert property (@(posedge clk) disable iff (reset)
    take && core_mode == pam_pkg::PAM_MODE_SHORT
      && (core_addr >= pam_pkg::PAM_SHORT_LIMIT || core_op != pam_pkg::PAM_OP_CLRLDST)
    |=> core_err && core_ack && !mem_req)
    else $error("short mode reach not enforced");

  a_jump_ext: assert property (@(posedge clk) disable iff (reset)
    take && core_mode == pam_pkg::PAM_MODE_EXTENDED && core_op == pam_pkg::PAM_OP_JUMP
    |=> fetch_addr == $past(core_addr) && core_ack && !core_err)
    else $error("jump target not loaded");

  a_immediate_op: assert property (@(posedge clk) disable iff (reset)
    take && core_mode == pam_pkg::PAM_MODE_IMMEDIATE && core_op != pam_pkg::PAM_OP_JUMP
    |=> core_rdata == $past(core_imm) && core_ack && !mem_req)
    else $error("immediate operand not from stream");

  a_pointer_write: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_we && core_mode != pam_pkg::PAM_MODE_EXTENDED
      && core_mode != pam_pkg::PAM_MODE_IMMEDIATE
      && core_mode != pam_pkg::PAM_MODE_INHERENT
      && core_addr[7:0] == pam_pkg::PAM_POINTER_OFS
    |=> pointer == $past(core_wdata) && core_ack && !mem_req)
    else $error("pointer write not stored");

  a_indirect_window: assert property (@(posedge clk) disable iff (reset)
    take && legal && core_mode == pam_pkg::PAM_MODE_DIRECT
      && core_addr[7:0] == pam_pkg::PAM_INDIRECT_OFS
      && pointer[7:6] == pam_pkg::PAM_WINDOW_SEL
    |=> mem_req && mem_addr == {$past(bank_select), $past(pointer[5:0])})
    else $error("indirect window access not mapped");

  a_reset_fetch: assert property (@(posedge clk)
    $fell(reset) |-> fetch_addr == pam_pkg::PAM_RESET_FETCH && core_ready && !mem_req)
    else $error("fetch not at reset address");

  a_read_return: assert property (@(posedge clk) disable iff (reset)
    clk_en && regs_r.state == pam_pkg::PAM_ST_RDWAIT
    |=> core_ack && core_rdata == $past(mem_rdata))
    else $error("read data not returned");

endmodule : paged_address_mapper

// ### verif/pam_mem_model.sv
`timescale 1ns/1ps
module pam_mem_model (
  input  wire logic        clk,        // System clock
  input  wire logic        mem_req,    // Memory strobe pulse
  input  wire logic        mem_we,     // Write when high
  input  wire logic [13:0] mem_addr,   // Physical address
  input  wire logic [7:0]  mem_wdata,  // Write data
  output logic      [7:0]  mem_rdata   // Read data, cycle after strobe
);
  // Flat 16 KB space, pages in 64-byte steps
  logic [7:0] mem [16384];
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 8'(i) ^ 8'(i >> 6);
    mem_rdata = 8'h5a;
  end
  // Data valid for one cycle only, then inverted garbage
  always @(posedge clk)
  begin
    if (mem_req === 1'b1)
    begin
      mem_rdata <= mem[mem_addr];
      if (mem_we === 1'b1)
        mem[mem_addr] <= mem_wdata;
    end
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule : pam_mem_model

// ### verif/test_paged_address_mapper.sv
`timescale 1ns/1ps
module test_paged_address_mapper;
  logic               clk;
  logic               reset;
  logic               clk_en;
  logic               core_req;
  logic               core_we;
  pam_pkg::pam_mode_t core_mode;
  pam_pkg::pam_op_t   core_op;
  logic [13:0]        core_addr;
  logic [13:0]        fetch_addr;
  logic [13:0]        mem_addr;
  logic [13:0]        ma;
  logic [7:0]         core_wdata;
  logic [7:0]         core_imm;
  logic [7:0]         core_rdata;
  logic [7:0]         bank_select;
  logic [7:0]         pointer;
  logic [7:0]         mem_wdata;
  logic [7:0]         mem_rdata;
  logic [7:0]         pg;
  logic [5:0]         ofs;
  logic               core_ready;
  logic               core_ack;
  logic               core_err;
  logic               mem_req;
  logic               mem_we;
  int                 n_errors = 0;
  int                 compares = 0;
  int                 cyc = 0;
  int                 lat;
  int                 n_mreq = 0;
  int                 m;

  paged_address_mapper i_paged_address_mapper (
    .clk(clk), .reset(reset), .clk_en(clk_en), .core_req(core_req), .core_we(core_we),
    .core_mode(core_mode), .core_op(core_op), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_imm(core_imm), .core_ready(core_ready),
    .core_ack(core_ack), .core_err(core_err), .core_rdata(core_rdata),
    .fetch_addr(fetch_addr), .bank_select(bank_select), .pointer(pointer),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  pam_mem_model i_pam_mem_model (
    .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Strobe capture and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (mem_req === 1'b1)
    begin
      n_mreq++;
      ma = mem_addr;
    end
    if (cyc == 4000)
    begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] exp_mem(input logic [13:0] a);
    return a[7:0] ^ a[13:6];
  endfunction : exp_mem

  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Latency el, 0 means refused with error after one cycle
  task automatic op_chk(input logic we, input pam_pkg::pam_mode_t md, input pam_pkg::pam_op_t o,
                        input logic [13:0] a, input logic [7:0] d, input int el);
    @(posedge clk);
    core_req <= 1'b1;
    core_we <= we;
    core_mode <= md;
    core_op <= o;
    core_addr <= a;
    core_wdata <= d;
    core_imm <= d;
    @(posedge clk);
    core_req <= 1'b0;
    lat = 1;
    #1;
    chk("ready", {13'h0, el < 2}, {13'h0, core_ready});
    while (core_ack !== 1'b1 && lat < 8)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk("latency", 14'(el == 0 ? 1 : el), 14'(lat));
    chk("err", {13'h0, el == 0}, {13'h0, core_err});
  endtask : op_chk

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    core_req = 1'b0;
    core_we = 1'b0;
    core_mode = pam_pkg::PAM_MODE_INHERENT;
    core_op = pam_pkg::PAM_OP_OTHER;
    core_addr = '0;
    core_wdata = '0;
    core_imm = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("fetch", 14'h3ffd, fetch_addr);
    chk("bank", 14'h000, {6'h0, bank_select});
    $display("test reset done");
    op_chk('1, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h1f, 8'h05, 1);
    chk("bank", 14'h005, {6'h0, bank_select});
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_CLRLDST, 14'hc2, 8'h00, 3);
    chk("mem_addr", 14'h0142, ma);
    chk("rdata", {6'h0, exp_mem(14'h0142)}, {6'h0, core_rdata});
    $display("test bank done");
    for (int i = 0; i < 3; i++)
    begin
      pg = i == 0 ? 8'h00 : (i == 1 ? 8'hf8 : 8'hff);
      op_chk('1, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h1f, pg, 1);
      for (int k = 0; k < 2; k++)
      begin
        ofs = k == 0 ? 6'h00 : 6'h3f;
        op_chk('1, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, {8'h03, ofs}, ~pg, 2);
        chk("mem_addr", {pg, ofs}, ma);
        op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_ARITH, {8'h03, ofs}, 8'h00, 3);
        chk("rdata", {6'h0, ~pg}, {6'h0, core_rdata});
      end
    end
    $display("test pages done");
    op_chk('1, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h0f, 8'hc5, 1);
    chk("pointer", 14'h0c5, {6'h0, pointer});
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, 14'h0e, 8'h00, 3);
    chk("mem_addr", 14'h3fc5, ma);
    chk("rdata", {6'h0, exp_mem(14'h3fc5)}, {6'h0, core_rdata});
    op_chk('1, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h0f, 8'h40, 1);
    op_chk('1, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, 14'h0e, 8'h77, 2);
    chk("mem_addr", 14'h0040, ma);
    op_chk('0, pam_pkg::PAM_MODE_TINY, pam_pkg::PAM_OP_ARITH, 14'h0e, 8'h00, 3);
    chk("rdata", 14'h077, {6'h0, core_rdata});
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, 14'h40, 8'h00, 3);
    chk("mem_addr", 14'h0040, ma);
    chk("rdata", 14'h077, {6'h0, core_rdata});
    op_chk('1, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h0f, 8'h05, 1);
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, 14'h0e, 8'h00, 3);
    chk("mem_addr", 14'h0005, ma);
    chk("rdata", {6'h0, exp_mem(14'h0005)}, {6'h0, core_rdata});
    $display("test indirect done");
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_OTHER, 14'h100, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_TINY, pam_pkg::PAM_OP_ARITH, 14'h10, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_TINY, pam_pkg::PAM_OP_CLRLDST, 14'h05, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_TINY, pam_pkg::PAM_OP_ARITH, 14'h05, 8'h00, 3);
    chk("mem_addr", 14'h0005, ma);
    op_chk('0, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h20, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_ARITH, 14'h1e, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_SHORT, pam_pkg::PAM_OP_CLRLDST, 14'h1e, 8'h00, 3);
    op_chk('1, pam_pkg::PAM_MODE_TINY, pam_pkg::PAM_OP_ARITH, 14'h1f, 8'h33, 0);
    chk("bank", 14'h0ff, {6'h0, bank_select});
    op_chk('0, pam_pkg::PAM_MODE_DIRECT, pam_pkg::PAM_OP_JUMP, 14'h40, 8'h00, 0);
    op_chk('0, pam_pkg::PAM_MODE_EXTENDED, pam_pkg::PAM_OP_CLRLDST, 14'h40, 8'h00, 0);
    chk("fetch", 14'h3ffd, fetch_addr);
    op_chk('0, pam_pkg::PAM_MODE_EXTENDED, pam_pkg::PAM_OP_JUMP, 14'h3fff, 8'h00, 1);
    chk("fetch", 14'h3fff, fetch_addr);
    $display("test reach done");
    // Request held while the clock enable is low must not be taken
    @(posedge clk);
    clk_en <= 1'b0;
    core_req <= 1'b1;
    core_we <= 1'b1;
    core_mode <= pam_pkg::PAM_MODE_SHORT;
    core_op <= pam_pkg::PAM_OP_CLRLDST;
    core_addr <= 14'h1f;
    core_wdata <= 8'h3c;
    repeat (3) @(posedge clk);
    #1;
    chk("frozen bank", 14'h0ff, {6'h0, bank_select});
    chk("frozen ack", 14'h000, {13'h0, core_ack});
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    core_req <= 1'b0;
    #1;
    chk("bank", 14'h03c, {6'h0, bank_select});
    $display("test clock enable done");
    m = n_mreq;
    op_chk('0, pam_pkg::PAM_MODE_IMMEDIATE, pam_pkg::PAM_OP_ARITH, 14'h00, 8'ha5, 1);
    chk("rdata", 14'h0a5, {6'h0, core_rdata});
    op_chk('0, pam_pkg::PAM_MODE_INHERENT, pam_pkg::PAM_OP_OTHER, 14'h00, 8'h00, 1);
    chk("mem_req count", 14'(m), 14'(n_mreq));
    $display("test immediate done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("fetch", 14'h3ffd, fetch_addr);
    chk("pointer", 14'h000, {6'h0, pointer});
    chk("bank", 14'h000, {6'h0, bank_select});
    $display("test second reset done");
    stop_test();
  end
endmodule : test_paged_address_mapper
